//--- rtl/tmi_io_ports.sv
// tmi_io_ports: three general purpose i/o ports of a tv tuning mcu
// assumes: pins enter asynchronously; serial peripheral signals come from CLK_SYS logic
//
// Behaviour
// RULE_01 - each line is output, or input with or without pull-up, by direction bits
// RULE_02 - first port lines 4..7 are open-drain with no pull-up
// RULE_03 - first port lines 0..3 drive push-pull when outputs
// RULE_04 - second port has lines 0..2 and 4..6 only, each output or input with pull-up; the code gives an input its pull-up only while its pull bit is set
// RULE_05 - third port lines 0..3 only pull low or release in output mode
// RULE_06 - third port lines 4..7 are open-drain with no pull-up
// RULE_07 - third port lines 0,1,3 pull low if port value or serial signal is low
// RULE_08 - serial clock on line 0, data on line 1, bus select on line 3
// RULE_09 - third port lines 4 and 6 feed programmable edge latches raising interrupts
// RULE_10 - line 4 latch goes to power interrupt, line 6 latch to remote nmi
// RULE_11 - latch stays set until software clears it; polarity is software set
// RULE_12 - idle serial peripheral leaves the port value alone on shared lines
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "tmi_params.svh"
module tmi_io_ports (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST,
  input  wire logic [`TMI_ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [7:0]             REG_RDATA,
  input  wire logic [7:0]             FIRST_LINES_IN,
  output logic      [7:0]             FIRST_LINES_OUT,
  output logic      [7:0]             FIRST_LINES_OE,
  output logic      [7:0]             FIRST_LINES_PU,
  input  wire logic [7:0]             SECOND_LINES_IN,
  output logic      [7:0]             SECOND_LINES_OUT,
  output logic      [7:0]             SECOND_LINES_OE,
  output logic      [7:0]             SECOND_LINES_PU,
  input  wire logic [7:0]             THIRD_LINES_IN,
  output logic      [7:0]             THIRD_LINES_OUT,
  output logic      [7:0]             THIRD_LINES_OE,
  output logic      [7:0]             THIRD_LINES_PU,
  input  wire logic                   SER_ACTIVE,
  input  wire logic                   SER_SCL,
  input  wire logic                   SER_SDA,
  input  wire logic                   SER_BUS_SELECT,
  output logic                        PWR_IRQ,
  output logic                        REMOTE_NMI_IRQ
);
  // drive of one port: {pin level, output enable}; open-drain lines never drive high
  function automatic logic [15:0] port_drive(
    input tmi_pkg::tmi_byte_t data,
    input tmi_pkg::tmi_byte_t dir,
    input tmi_pkg::tmi_byte_t od_mask,
    input tmi_pkg::tmi_byte_t impl_mask
  );
    tmi_pkg::tmi_byte_t lvl;
    tmi_pkg::tmi_byte_t oe;
    lvl = data & ~od_mask & impl_mask;
    oe  = dir & impl_mask & (~od_mask | ~data);
    return {lvl, oe};
  endfunction

  // pull-up only on inputs that offer one
  function automatic tmi_pkg::tmi_byte_t port_pull(
    input tmi_pkg::tmi_byte_t dir,
    input tmi_pkg::tmi_byte_t pull,
    input tmi_pkg::tmi_byte_t pull_mask
  );
    return ~dir & pull & pull_mask;
  endfunction

  // software registers
  tmi_pkg::tmi_byte_t a_data_r, a_dir_r, a_pull_r;
  tmi_pkg::tmi_byte_t b_data_r, b_dir_r, b_pull_r;
  tmi_pkg::tmi_byte_t c_data_r, c_dir_r, c_pull_r;
  tmi_pkg::tmi_byte_t lctl_r, rdata_r;
  tmi_pkg::tmi_byte_t a_data_nxt, a_dir_nxt, a_pull_nxt;
  tmi_pkg::tmi_byte_t b_data_nxt, b_dir_nxt, b_pull_nxt;
  tmi_pkg::tmi_byte_t c_data_nxt, c_dir_nxt, c_pull_nxt;
  tmi_pkg::tmi_byte_t lctl_nxt, rdata_nxt;
  logic               clr_pwr, clr_rc;

  // pin side
  logic [23:0]        pins_sync;
  tmi_pkg::tmi_byte_t a_pins, b_pins, c_pins;
  tmi_pkg::tmi_byte_t c_value;
  logic               flag_pwr, flag_rc;
  logic [15:0]        a_drv, b_drv, c_drv;

  // registered outputs
  tmi_pkg::tmi_byte_t a_out_r, a_oe_r, a_pu_r;
  tmi_pkg::tmi_byte_t b_out_r, b_oe_r, b_pu_r;
  tmi_pkg::tmi_byte_t c_out_r, c_oe_r, c_pu_r;
  logic               pwr_irq_r, rc_irq_r;

  tmi_sync2 #(
    .WIDTH (24)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst  (RST),
    .din  ({THIRD_LINES_IN, SECOND_LINES_IN, FIRST_LINES_IN}),
    .dout (pins_sync)
  );

  assign a_pins = pins_sync[7:0];
  assign b_pins = pins_sync[15:8] & `TMI_B_IMPL_MASK;
  assign c_pins = pins_sync[23:16];

  tmi_edge_latch u_latch_pwr (
    .clk   (CLK_SYS),
    .rst   (RST),
    .level (c_pins[`TMI_C_PWR_BIT]),
    .pol   (tmi_pkg::tmi_edge_e'(lctl_r[`TMI_LC_POL_PWR])),
    .clr   (clr_pwr),
    .flag  (flag_pwr)
  );

  tmi_edge_latch u_latch_rc (
    .clk   (CLK_SYS),
    .rst   (RST),
    .level (c_pins[`TMI_C_RC_BIT]),
    .pol   (tmi_pkg::tmi_edge_e'(lctl_r[`TMI_LC_POL_RC])),
    .clr   (clr_rc),
    .flag  (flag_rc)
  );

  // register file: writes, write-one-to-clear latches, read data for one cycle
  always_comb begin
    a_data_nxt = a_data_r;
    a_dir_nxt  = a_dir_r;
    a_pull_nxt = a_pull_r;
    b_data_nxt = b_data_r;
    b_dir_nxt  = b_dir_r;
    b_pull_nxt = b_pull_r;
    c_data_nxt = c_data_r;
    c_dir_nxt  = c_dir_r;
    c_pull_nxt = c_pull_r;
    lctl_nxt   = lctl_r;
    clr_pwr    = 1'b0;
    clr_rc     = 1'b0;
    rdata_nxt  = `TMI_RST_BYTE;
    if (REG_WR) begin
      case (REG_ADDR)
        `TMI_R_A_DATA:     a_data_nxt = REG_WDATA;
        `TMI_R_A_DIR:      a_dir_nxt  = REG_WDATA; // see RULE_01
        `TMI_R_A_PULL:     a_pull_nxt = REG_WDATA & `TMI_A_PULL_MASK; // see RULE_02
        `TMI_R_B_DATA:     b_data_nxt = REG_WDATA & `TMI_B_IMPL_MASK; // see RULE_04
        `TMI_R_B_DIR:      b_dir_nxt  = REG_WDATA & `TMI_B_IMPL_MASK; // see RULE_04
        `TMI_R_B_PULL:     b_pull_nxt = REG_WDATA & `TMI_B_IMPL_MASK; // see RULE_04
        `TMI_R_C_DATA:     c_data_nxt = REG_WDATA;
        `TMI_R_C_DIR:      c_dir_nxt  = REG_WDATA;
        `TMI_R_C_PULL:     c_pull_nxt = REG_WDATA & `TMI_C_PULL_MASK; // see RULE_06
        `TMI_R_LATCH_CTL:  lctl_nxt   = REG_WDATA & `TMI_LC_MASK; // see RULE_11
        `TMI_R_LATCH_STAT: begin
          clr_pwr = REG_WDATA[`TMI_LS_PWR]; // see RULE_11
          clr_rc  = REG_WDATA[`TMI_LS_RC];
        end
        default: begin
        end
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `TMI_R_A_DATA:     rdata_nxt = a_data_r;
        `TMI_R_A_DIR:      rdata_nxt = a_dir_r;
        `TMI_R_A_PULL:     rdata_nxt = a_pull_r;
        `TMI_R_B_DATA:     rdata_nxt = b_data_r;
        `TMI_R_B_DIR:      rdata_nxt = b_dir_r;
        `TMI_R_B_PULL:     rdata_nxt = b_pull_r;
        `TMI_R_C_DATA:     rdata_nxt = c_data_r;
        `TMI_R_C_DIR:      rdata_nxt = c_dir_r;
        `TMI_R_C_PULL:     rdata_nxt = c_pull_r;
        `TMI_R_A_PINS:     rdata_nxt = a_pins;
        `TMI_R_B_PINS:     rdata_nxt = b_pins;
        `TMI_R_C_PINS:     rdata_nxt = c_pins;
        `TMI_R_LATCH_CTL:  rdata_nxt = lctl_r;
        `TMI_R_LATCH_STAT: begin
          rdata_nxt = `TMI_RST_BYTE;
          rdata_nxt[`TMI_LS_PWR] = flag_pwr;
          rdata_nxt[`TMI_LS_RC]  = flag_rc;
        end
        default:           rdata_nxt = `TMI_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      a_data_r <= `TMI_RST_BYTE;
      a_dir_r  <= `TMI_RST_BYTE;
      a_pull_r <= `TMI_RST_BYTE;
      b_data_r <= `TMI_RST_BYTE;
      b_dir_r  <= `TMI_RST_BYTE;
      b_pull_r <= `TMI_RST_BYTE;
      c_data_r <= `TMI_RST_BYTE;
      c_dir_r  <= `TMI_RST_BYTE;
      c_pull_r <= `TMI_RST_BYTE;
      lctl_r   <= `TMI_RST_BYTE;
      rdata_r  <= `TMI_RST_BYTE;
    end else begin
      a_data_r <= a_data_nxt;
      a_dir_r  <= a_dir_nxt;
      a_pull_r <= a_pull_nxt;
      b_data_r <= b_data_nxt;
      b_dir_r  <= b_dir_nxt;
      b_pull_r <= b_pull_nxt;
      c_data_r <= c_data_nxt;
      c_dir_r  <= c_dir_nxt;
      c_pull_r <= c_pull_nxt;
      lctl_r   <= lctl_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // pin drive; the serial signals only take part while the peripheral is active
  always_comb begin
    c_value = c_data_r;
    if (SER_ACTIVE) begin // see RULE_12
      c_value[`TMI_C_SCL_BIT] = c_data_r[`TMI_C_SCL_BIT] & SER_SCL; // see RULE_07 RULE_08
      c_value[`TMI_C_SDA_BIT] = c_data_r[`TMI_C_SDA_BIT] & SER_SDA; // see RULE_07 RULE_08
      c_value[`TMI_C_SEL_BIT] = c_data_r[`TMI_C_SEL_BIT] & SER_BUS_SELECT; // see RULE_08
    end
    a_drv = port_drive(a_data_r, a_dir_r, `TMI_A_OD_MASK, `TMI_ALL_LINES); // see RULE_02 RULE_03
    b_drv = port_drive(b_data_r, b_dir_r, `TMI_NO_LINES, `TMI_B_IMPL_MASK); // see RULE_04
    c_drv = port_drive(c_value, c_dir_r, `TMI_C_OD_MASK, `TMI_ALL_LINES); // see RULE_05 RULE_07
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      a_out_r   <= `TMI_RST_BYTE;
      a_oe_r    <= `TMI_RST_BYTE;
      a_pu_r    <= `TMI_RST_BYTE;
      b_out_r   <= `TMI_RST_BYTE;
      b_oe_r    <= `TMI_RST_BYTE;
      b_pu_r    <= `TMI_RST_BYTE;
      c_out_r   <= `TMI_RST_BYTE;
      c_oe_r    <= `TMI_RST_BYTE;
      c_pu_r    <= `TMI_RST_BYTE;
      pwr_irq_r <= 1'b0;
      rc_irq_r  <= 1'b0;
    end else begin
      a_out_r   <= a_drv[15:8];
      a_oe_r    <= a_drv[7:0];
      a_pu_r    <= port_pull(a_dir_r, a_pull_r, `TMI_A_PULL_MASK); // see RULE_01 RULE_02
      b_out_r   <= b_drv[15:8];
      b_oe_r    <= b_drv[7:0];
      b_pu_r    <= port_pull(b_dir_r, b_pull_r, `TMI_B_IMPL_MASK); // see RULE_04
      c_out_r   <= c_drv[15:8];
      c_oe_r    <= c_drv[7:0];
      c_pu_r    <= port_pull(c_dir_r, c_pull_r, `TMI_C_PULL_MASK); // see RULE_06
      pwr_irq_r <= flag_pwr & lctl_r[`TMI_LC_EN_PWR]; // see RULE_09 RULE_10
      rc_irq_r  <= flag_rc & lctl_r[`TMI_LC_EN_RC]; // see RULE_10
    end
  end

  assign REG_RDATA        = rdata_r;
  assign FIRST_LINES_OUT  = a_out_r;
  assign FIRST_LINES_OE   = a_oe_r;
  assign FIRST_LINES_PU   = a_pu_r;
  assign SECOND_LINES_OUT = b_out_r;
  assign SECOND_LINES_OE  = b_oe_r;
  assign SECOND_LINES_PU  = b_pu_r;
  assign THIRD_LINES_OUT  = c_out_r;
  assign THIRD_LINES_OE   = c_oe_r;
  assign THIRD_LINES_PU   = c_pu_r;
  assign PWR_IRQ          = pwr_irq_r;
  assign REMOTE_NMI_IRQ   = rc_irq_r;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_pull_follows_dir: assert property ( // see RULE_01
    1'b1 |=> FIRST_LINES_PU == (~$past(a_dir_r) & $past(a_pull_r) & `TMI_A_PULL_MASK))
    else $error("first port pull-up does not follow direction and pull bits");
  chk_first_od_high: assert property ( // see RULE_02
    (FIRST_LINES_OUT[7:4] == 4'h0) && (FIRST_LINES_PU[7:4] == 4'h0))
    else $error("first port upper lines drive high or pull up");
  chk_first_pushpull: assert property ( // see RULE_03
    1'b1 |=> (FIRST_LINES_OE[3:0] == $past(a_dir_r[3:0]))
         && (FIRST_LINES_OUT[3:0] == $past(a_data_r[3:0])))
    else $error("first port lower lines not push-pull");
  chk_second_gaps: assert property ( // see RULE_04
    ((SECOND_LINES_OE | SECOND_LINES_PU | SECOND_LINES_OUT) & ~`TMI_B_IMPL_MASK) == 8'h00)
    else $error("second port drives a missing line");
  chk_third_od: assert property ( // see RULE_05
    (THIRD_LINES_OUT == 8'h00) && (THIRD_LINES_PU[7:4] == 4'h0))
    else $error("third port drives high or pulls up an upper line");
  chk_scl_pulls_low: assert property ( // see RULE_07
    (c_dir_r[`TMI_C_SCL_BIT] && SER_ACTIVE && !SER_SCL) |=> THIRD_LINES_OE[`TMI_C_SCL_BIT])
    else $error("serial clock low did not pull its line");
  chk_select_release: assert property ( // see RULE_08
    (c_dir_r[`TMI_C_SEL_BIT] && c_data_r[`TMI_C_SEL_BIT] && SER_ACTIVE && SER_BUS_SELECT)
      |=> !THIRD_LINES_OE[`TMI_C_SEL_BIT])
    else $error("bus select line pulled while both sources high");
  chk_idle_serial: assert property ( // see RULE_12
    (!SER_ACTIVE && c_dir_r[`TMI_C_SDA_BIT] && c_data_r[`TMI_C_SDA_BIT])
      |=> !THIRD_LINES_OE[`TMI_C_SDA_BIT])
    else $error("idle serial peripheral disturbed the data line");
  chk_irq_route: assert property ( // see RULE_10
    1'b1 |=> (PWR_IRQ == ($past(flag_pwr) && $past(lctl_r[`TMI_LC_EN_PWR])))
         && (REMOTE_NMI_IRQ == ($past(flag_rc) && $past(lctl_r[`TMI_LC_EN_RC]))))
    else $error("latch not routed to its interrupt");
endmodule // tmi_io_ports

//--- common/tmi_params.svh
// tmi_params.svh: offsets, masks, reset values and bit positions of the tv mcu i/o ports
// assumes: included by bare name from design files; definitions only
`ifndef TMI_PARAMS_SVH
`define TMI_PARAMS_SVH

`define TMI_ADDR_W       4
// register offsets on the plain register port
`define TMI_R_A_DATA     4'h0
`define TMI_R_A_DIR      4'h1
`define TMI_R_A_PULL     4'h2
`define TMI_R_B_DATA     4'h3
`define TMI_R_B_DIR      4'h4
`define TMI_R_B_PULL     4'h5
`define TMI_R_C_DATA     4'h6
`define TMI_R_C_DIR      4'h7
`define TMI_R_C_PULL     4'h8
`define TMI_R_A_PINS     4'h9
`define TMI_R_B_PINS     4'hA
`define TMI_R_C_PINS     4'hB
`define TMI_R_LATCH_CTL  4'hC
`define TMI_R_LATCH_STAT 4'hD
// line masks
`define TMI_ALL_LINES    8'hFF
`define TMI_NO_LINES     8'h00
`define TMI_A_OD_MASK    8'hF0
`define TMI_A_PULL_MASK  8'h0F
`define TMI_B_IMPL_MASK  8'h77
`define TMI_C_OD_MASK    8'hFF
`define TMI_C_PULL_MASK  8'h0F
`define TMI_LC_MASK      8'h0F
`define TMI_RST_BYTE     8'h00
// port c line numbers
`define TMI_C_SCL_BIT    0
`define TMI_C_SDA_BIT    1
`define TMI_C_SEL_BIT    3
`define TMI_C_PWR_BIT    4
`define TMI_C_RC_BIT     6
// latch control and status bits
`define TMI_LC_POL_PWR   0
`define TMI_LC_POL_RC    1
`define TMI_LC_EN_PWR    2
`define TMI_LC_EN_RC     3
`define TMI_LS_PWR       0
`define TMI_LS_RC        1

`endif

//--- common/tmi_pkg.sv
// tmi_pkg: types shared by the tv mcu i/o port design
// assumes: compiled before every design file
package tmi_pkg;
  typedef logic [7:0] tmi_byte_t;
  typedef enum logic {TMI_EDGE_FALL, TMI_EDGE_RISE} tmi_edge_e;
endpackage

//--- rtl/tmi_sync2.sv
// tmi_sync2: two flip-flop synchroniser for pin levels
// assumes: inputs are asynchronous to CLK_SYS; reset is synchronous
`timescale 1ns/1ps
module tmi_sync2 #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  // meta_r is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule // tmi_sync2

//--- rtl/tmi_edge_latch.sv
// tmi_edge_latch: sticky edge latch with selectable polarity
// assumes: level is already synchronised to clk; clr is a one-cycle pulse
`timescale 1ns/1ps
module tmi_edge_latch (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              level,
  input  tmi_pkg::tmi_edge_e     pol,
  input  wire logic              clr,
  output logic                   flag
);
  logic [1:0] warm_r;
  logic [1:0] warm_nxt;
  logic prev_r;
  logic primed_r;
  logic flag_r;
  logic prev_nxt;
  logic primed_nxt;
  logic flag_nxt;
  logic hit;

  always_comb begin
    prev_nxt   = level;
    // the synchroniser shows its reset zero for two cycles; edges count only after that,
    // so a pin already high at reset release is no event
    warm_nxt   = {warm_r[0], 1'b1};
    primed_nxt = warm_r[1];
    if (pol == tmi_pkg::TMI_EDGE_RISE) begin
      hit = primed_r & level & ~prev_r; // see RULE_11
    end else begin
      hit = primed_r & ~level & prev_r; // see RULE_11
    end
    flag_nxt = hit | (flag_r & ~clr); // see RULE_09 RULE_11
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      warm_r   <= 2'h0;
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
      flag_r   <= 1'b0;
    end else begin
      warm_r   <= warm_nxt;
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
      flag_r   <= flag_nxt;
    end
  end

  assign flag = flag_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rise;
    !level ##1 level;
  endsequence
  sequence s_fall;
    level ##1 !level;
  endsequence

  chk_rise_sets_flag: assert property ( // see RULE_11
    (s_rise ##0 (pol == tmi_pkg::TMI_EDGE_RISE) ##0 primed_r) |=> flag_r)
    else $error("rising edge did not set the latch");
  chk_fall_sets_flag: assert property ( // see RULE_09
    (s_fall ##0 (pol == tmi_pkg::TMI_EDGE_FALL) ##0 $past(primed_r)) |=> flag_r)
    else $error("falling edge did not set the latch");
  chk_flag_sticky: assert property ( // see RULE_11
    (flag_r && !clr) |=> flag_r)
    else $error("latch dropped without a clear");
  chk_flag_cleared: assert property ( // see RULE_11
    (flag_r && clr && !hit) |=> !flag_r)
    else $error("clear did not drop the latch");
endmodule // tmi_edge_latch

//--- tb/tmi_board_model.sv
// tmi_board_model: board side of one 8-line port, resolving each pad level
// assumes: where bench and module both drive a line the module wins; oe/out/pu come from the port
`timescale 1ns/1ps
module tmi_board_model (
  input  wire logic       clk,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad
);
  // an undriven line without pull-up toggles, so a stale level cannot pass a check
  logic [7:0] float_r = 8'h5A;

  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) pad[i] = out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pu[i]) pad[i] = 1'b1;
      else pad[i] = float_r[i];
    end
  end
endmodule // tmi_board_model

//--- tb/tmi_io_ports_test.sv
// tmi_io_ports_test: self-checking bench for the three i/o ports
// assumes: board models resolve the pads; the bench plays the serial peripheral
`timescale 1ns/1ps
`include "tmi_params.svh"
module tmi_io_ports_test;
  typedef struct {
    logic [1:0]         port;
    tmi_pkg::tmi_byte_t dir, data, pull, oe, out, pu, rbd, rbp;
  } tmi_row_s;

  logic               clk_sys, rst, reg_wr, reg_rd, pwr_irq, nmi_irq;
  logic               ser_active, ser_scl, ser_sda, ser_sel;
  logic [3:0]         reg_addr, base;
  logic [2:0]         sv;
  tmi_pkg::tmi_byte_t reg_wdata, reg_rdata;
  tmi_pkg::tmi_byte_t p_in[3], p_out[3], p_oe[3], p_pu[3], ext_en[3], ext_val[3];
  int                 fail_count, n_checks;
  tmi_pkg::tmi_byte_t ser_oe[3] = '{8'h01, 8'h02, 8'h08};
  // port, dir, data, pull, then oe, driven out, pull-up, dir and pull read back
  tmi_row_s rows[8] = '{
    '{2'h0, 8'hFF, 8'hA5, 8'hFF, 8'h5F, 8'h05, 8'h00, 8'hFF, 8'h0F},
    '{2'h0, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h0F},
    '{2'h0, 8'h3C, 8'h0F, 8'hC3, 8'h3C, 8'h0C, 8'h03, 8'h3C, 8'h03},
    '{2'h1, 8'hFF, 8'h5A, 8'h00, 8'h77, 8'h52, 8'h00, 8'h77, 8'h00},
    '{2'h1, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h77, 8'h00, 8'h77},
    '{2'h2, 8'hFF, 8'h96, 8'hFF, 8'h69, 8'h00, 8'h00, 8'hFF, 8'h0F},
    '{2'h2, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h0F},
    '{2'h2, 8'hF0, 8'h30, 8'h5A, 8'hC0, 8'h00, 8'h0A, 8'hF0, 8'h0A}};

  tmi_io_ports u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FIRST_LINES_IN(p_in[0]), .FIRST_LINES_OUT(p_out[0]),
    .FIRST_LINES_OE(p_oe[0]), .FIRST_LINES_PU(p_pu[0]),
    .SECOND_LINES_IN(p_in[1]), .SECOND_LINES_OUT(p_out[1]),
    .SECOND_LINES_OE(p_oe[1]), .SECOND_LINES_PU(p_pu[1]),
    .THIRD_LINES_IN(p_in[2]), .THIRD_LINES_OUT(p_out[2]),
    .THIRD_LINES_OE(p_oe[2]), .THIRD_LINES_PU(p_pu[2]),
    .SER_ACTIVE(ser_active), .SER_SCL(ser_scl), .SER_SDA(ser_sda),
    .SER_BUS_SELECT(ser_sel), .PWR_IRQ(pwr_irq), .REMOTE_NMI_IRQ(nmi_irq));

  for (genvar g = 0; g < 3; g++) begin : g_pad
    tmi_board_model u_board (
      .clk(clk_sys), .oe(p_oe[g]), .out(p_out[g]), .pu(p_pu[g]),
      .ext_en(ext_en[g]), .ext_val(ext_val[g]), .pad(p_in[g]));
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk8(input tmi_pkg::tmi_byte_t got, input tmi_pkg::tmi_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input tmi_pkg::tmi_byte_t d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, input tmi_pkg::tmi_byte_t exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask

  task automatic ser(input logic act, input logic [2:0] v);
    @(posedge clk_sys);
    ser_active <= act;
    ser_scl    <= v[0];
    ser_sda    <= v[1];
    ser_sel    <= v[2];
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // pad edges reach the flags through the 2-flop sync, so allow 6 cycles
  task automatic pad_c(input tmi_pkg::tmi_byte_t v);
    @(posedge clk_sys);
    ext_val[2] <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {ser_active, ser_scl, ser_sda, ser_sel} = 4'h7;
    fail_count = 0;
    n_checks = 0;
    for (int p = 0; p < 3; p++) begin
      ext_en[p] = 8'h00;
      ext_val[p] = 8'h00;
    end
    // the latch inputs rest high from the start, so no stray edge sets a flag
    ext_en[2] = 8'h50;
    ext_val[2] = 8'h50;
    repeat (4) @(posedge clk_sys);
    #1;
    chk8(p_oe[0] | p_oe[1] | p_oe[2] | p_pu[0] | p_pu[1] | p_pu[2], 8'h00);
    chk1(pwr_irq | nmi_irq, 1'b0);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 16; a++) begin
      if (a < 9 || a > 11) rd(4'(a), 8'h00);
    end
    foreach (rows[i]) begin
      base = 4'(3 * rows[i].port);
      wr(base + 4'h1, rows[i].dir);
      wr(base, rows[i].data);
      wr(base + 4'h2, rows[i].pull);
      repeat (2) @(posedge clk_sys);
      #1;
      chk8(p_oe[rows[i].port], rows[i].oe);
      chk8(p_out[rows[i].port] & p_oe[rows[i].port], rows[i].out);
      chk8(p_pu[rows[i].port], rows[i].pu);
      rd(base + 4'h1, rows[i].rbd);
      rd(base + 4'h2, rows[i].rbp);
    end
    // pins read back: inputs follow the board, open-drain lines read their own low
    wr(`TMI_R_A_DIR, 8'h00);
    wr(`TMI_R_C_DIR, 8'h0F);
    wr(`TMI_R_C_DATA, 8'h00);
    @(posedge clk_sys);
    ext_en[0] <= 8'hFF;
    ext_val[0] <= 8'h96;
    ext_en[2] <= 8'hF0;
    ext_val[2] <= 8'hA0;
    repeat (4) @(posedge clk_sys);
    rd(`TMI_R_A_PINS, 8'h96);
    rd(`TMI_R_C_PINS, 8'hA0);
    chk8(p_out[2] & p_oe[2], 8'h00);
    // serial signals pull the shared lines low only while active
    wr(`TMI_R_C_DIR, 8'h0B);
    wr(`TMI_R_C_DATA, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      sv = 3'h7;
      sv[k] = 1'b0;
      ser(1'b1, sv);
      chk8(p_oe[2], ser_oe[k]);
      ser(1'b0, sv);
      chk8(p_oe[2], 8'h00);
    end
    wr(`TMI_R_C_DATA, 8'hF4);
    ser(1'b1, 3'h7);
    chk8(p_oe[2], 8'h0B);
    wr(`TMI_R_C_DIR, 8'h00);
    ser(1'b1, 3'h0);
    chk8(p_oe[2], 8'h00);
    ser(1'b0, 3'h7);
    // edge latches: power on rising edges, remote on falling edges
    @(posedge clk_sys);
    ext_en[2] <= 8'h50;
    ext_val[2] <= 8'h50;
    repeat (4) @(posedge clk_sys);
    wr(`TMI_R_LATCH_CTL, 8'h0D);
    wr(`TMI_R_LATCH_STAT, 8'h03);
    pad_c(8'h40);
    chk1(pwr_irq, 1'b0);
    pad_c(8'h50);
    chk1(pwr_irq, 1'b1);
    chk1(nmi_irq, 1'b0);
    pad_c(8'h40);
    chk1(pwr_irq, 1'b1);
    rd(`TMI_R_LATCH_STAT, 8'h01);
    wr(`TMI_R_LATCH_STAT, 8'h01);
    repeat (3) @(posedge clk_sys);
    #1;
    chk1(pwr_irq, 1'b0);
    pad_c(8'h00);
    chk1(nmi_irq, 1'b1);
    chk1(pwr_irq, 1'b0);
    rd(`TMI_R_LATCH_STAT, 8'h02);
    // a disabled latch still records its edge but raises nothing
    wr(`TMI_R_LATCH_CTL, 8'h01);
    pad_c(8'h00);
    wr(`TMI_R_LATCH_STAT, 8'h03);
    pad_c(8'h50);
    chk1(pwr_irq, 1'b0);
    rd(`TMI_R_LATCH_STAT, 8'h01);
    // second reset with the power line held high: rising polarity must see no edge
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk8(p_oe[0] | p_oe[1] | p_oe[2] | p_pu[0] | p_pu[1] | p_pu[2], 8'h00);
    chk1(pwr_irq | nmi_irq, 1'b0);
    wr(`TMI_R_LATCH_CTL, 8'h05);
    repeat (6) @(posedge clk_sys);
    #1;
    chk1(pwr_irq, 1'b0);
    rd(`TMI_R_LATCH_STAT, 8'h00);
    summarize();
  end
endmodule // tmi_io_ports_test
